// File: design/srs_seq.sv
// Purpose: Two-wire slave read sequencer of a 512 x 8 nonvolatile memory
// Assumes: Core clock far faster than the link clock; link clock stops outside frames
// Notes: Link pins are oversampled in the core domain; the open-drain output stage
// Notes: runs on the falling link clock edge
`timescale 1ns/100ps
`include "srs_regs.svh"

module srs_seq #(
  parameter logic [3:0] DEV_TYPE = 4'h5, // Arbitrary value
  parameter int TWR_CYCLES = `SRS_TWR_NS / `SRS_CLK_NS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_clk,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_val,
  output logic sda_oe,
  output logic standby,
  output logic write_busy
);
  import srs_pkg::*;

  localparam int BW = $clog2(TWR_CYCLES + 1);
  localparam logic [BW-1:0] BUSY_LOAD = BW'(TWR_CYCLES);
  localparam logic [BW-1:0] BUSY_ONE = BW'(1);

  // Pin synchronisers and one stage of history
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;

  // Reset to the idle bus level, so release from reset sees no false start
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_pin;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      sda_m_q <= sda_pin;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  srs_evt_t evt;
  wire scl_high = scl_s_q & scl_p_q;
  assign evt.start = scl_high & sda_p_q & ~sda_s_q;
  assign evt.stop = scl_high & ~sda_p_q & sda_s_q;
  assign evt.rise = scl_s_q & ~scl_p_q;

  // Core state
  srs_state_t state_q, state_d;
  logic [`SRS_BIT_CNT_W-1:0] bitc_q, bitc_d;
  logic [`SRS_DATA_W-1:0] sh_q, sh_d;
  logic [`SRS_ADDR_W-1:0] addr_q, addr_d;
  logic bank_q, bank_d;
  logic rd_q, rd_d;
  logic drv_q, drv_d;
  logic gate_q, gate_d;
  logic wr_pend_q, wr_pend_d;
  logic [BW-1:0] busy_cnt_q, busy_cnt_d;
  logic mem_we;

  logic [`SRS_DATA_W-1:0] mem [2**`SRS_ADDR_W];

  // Byte assembly and decode
  wire [`SRS_DATA_W-1:0] rx_byte = {sh_q[`SRS_DATA_W-2:0], sda_s_q};
  srs_slave_addr_t sa;
  assign sa = srs_slave_addr_t'(rx_byte);
  wire dev_hit = (sa.dev_type == DEV_TYPE);
  wire last_bit = (bitc_q == `SRS_BIT_LAST);
  wire [`SRS_BIT_CNT_W-1:0] bitc_inc = bitc_q + `SRS_BIT_ONE;
  wire [`SRS_DATA_W-1:0] rd_byte = mem[addr_q];
  wire [`SRS_ADDR_W-1:0] addr_inc = addr_q + `SRS_ADDR_ONE;
  // Page writes wrap inside the low address bits only
  wire [`SRS_PAGE_W-1:0] page_inc = addr_q[`SRS_PAGE_W-1:0] + `SRS_PAGE_ONE;
  // Every read byte comes from the counter, first or sequential
  wire [`SRS_DATA_W-1:0] rd_first_sh = {rd_byte[`SRS_DATA_W-2:0], 1'b0};
  wire rd_first_drv = ~rd_byte[`SRS_DATA_W-1];
  wire master_ack = ~sda_s_q;
  wire in_idle = (state_q == SRS_IDLE);
  wire busy = (busy_cnt_q != '0);
  wire start_ok = evt.start & ~busy;

  always_comb begin
    state_d = state_q;
    bitc_d = bitc_q;
    sh_d = sh_q;
    addr_d = addr_q;
    bank_d = bank_q;
    rd_d = rd_q;
    drv_d = drv_q;
    wr_pend_d = wr_pend_q;
    busy_cnt_d = busy ? busy_cnt_q - BUSY_ONE : busy_cnt_q;
    mem_we = 1'b0;
    if (evt.stop) begin
      state_d = SRS_IDLE;
      drv_d = 1'b0;
      if (wr_pend_q) begin
        busy_cnt_d = BUSY_LOAD;
      end
      wr_pend_d = 1'b0;
    end else if (start_ok) begin
      // Also covers the repeated start of a random read
      state_d = SRS_DEV;
      bitc_d = `SRS_BIT_ZERO;
      drv_d = 1'b0;
    end else if (evt.rise) begin
      case (state_q)
        SRS_DEV: begin
          sh_d = rx_byte;
          bitc_d = bitc_inc;
          if (last_bit) begin
            bitc_d = `SRS_BIT_ZERO;
            if (dev_hit) begin
              state_d = SRS_DEV_ACK;
              drv_d = 1'b1;
              rd_d = sa.rd;
              bank_d = sa.bank_select_bit;
            end else begin
              state_d = SRS_IDLE;
            end
          end
        end
        SRS_DEV_ACK: begin
          if (rd_q) begin
            // First byte of any read comes from the counter
            state_d = SRS_RDATA;
            sh_d = rd_first_sh;
            drv_d = rd_first_drv;
            addr_d = addr_inc;
          end else begin
            state_d = SRS_WADDR;
            drv_d = 1'b0;
          end
        end
        SRS_WADDR: begin
          sh_d = rx_byte;
          bitc_d = bitc_inc;
          if (last_bit) begin
            addr_d = {bank_q, rx_byte};
            drv_d = 1'b1;
            state_d = SRS_RX_ACK;
          end
        end
        SRS_RX_ACK: begin
          drv_d = 1'b0;
          bitc_d = `SRS_BIT_ZERO;
          state_d = SRS_WDATA;
        end
        SRS_WDATA: begin
          sh_d = rx_byte;
          bitc_d = bitc_inc;
          if (last_bit) begin
            // Only a real data byte arms the write cycle
            mem_we = 1'b1;
            wr_pend_d = 1'b1;
            addr_d = {addr_q[`SRS_ADDR_W-1:`SRS_PAGE_W], page_inc};
            drv_d = 1'b1;
            state_d = SRS_RX_ACK;
          end
        end
        SRS_RDATA: begin
          bitc_d = bitc_inc;
          if (last_bit) begin
            drv_d = 1'b0;
            state_d = SRS_RACK;
          end else begin
            drv_d = ~sh_q[`SRS_DATA_W-1];
            sh_d = sh_q << 1;
          end
        end
        SRS_RACK: begin
          bitc_d = `SRS_BIT_ZERO;
          if (master_ack) begin
            state_d = SRS_RDATA;
            sh_d = rd_first_sh;
            drv_d = rd_first_drv;
            addr_d = addr_inc;
          end else begin
            // No acknowledge: release and wait for the stop
            state_d = SRS_IDLE;
            drv_d = 1'b0;
          end
        end
        default: begin
          state_d = SRS_IDLE;
        end
      endcase
    end
  end

  // Shut in idle and over the address bits: the link flop has no reset
  // and holds a known value only after the first falling edge
  wire addr_phase_d = (state_d == SRS_DEV);
  assign gate_d = (state_d != SRS_IDLE) & ~addr_phase_d;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= SRS_IDLE;
      bitc_q <= `SRS_BIT_ZERO;
    end else begin
      state_q <= state_d;
      bitc_q <= bitc_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sh_q <= '0;
      addr_q <= '0;
    end else begin
      sh_q <= sh_d;
      addr_q <= addr_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bank_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      bank_q <= bank_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drv_q <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      drv_q <= drv_d;
      gate_q <= gate_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      busy_cnt_q <= '0;
    end else begin
      wr_pend_q <= wr_pend_d;
      busy_cnt_q <= busy_cnt_d;
    end
  end

  // Array holds its contents through reset
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[addr_q] <= rx_byte;
    end
  end

  // Link domain output stage. drv_q settles within a few core cycles of the
  // rising link edge and stays put until the falling edge, so it is sampled
  // there without a synchroniser. No reset: gate_q masks it until in use.
  logic drive_link_q;

  always_ff @(negedge scl_clk) begin
    drive_link_q <= drv_q;
  end

  assign sda_val = 1'b0;
  assign sda_oe = drive_link_q & gate_q;
  assign standby = in_idle & ~busy;
  assign write_busy = busy;

endmodule : srs_seq

// File: design/srs_regs.svh
// Purpose: Named constants of the serial memory read sequencer
// Assumes: Core clock of 40 ns period
// Notes: Definitions only
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH

`define SRS_ADDR_W 9
`define SRS_DATA_W 8
`define SRS_BIT_CNT_W 4
`define SRS_BIT_ZERO 4'h0
`define SRS_BIT_ONE 4'h1
`define SRS_BIT_LAST 4'h7
`define SRS_ADDR_ONE 9'h001
`define SRS_PAGE_W 4
`define SRS_PAGE_ONE 4'h1
`define SRS_TWR_NS 10000000
`define SRS_CLK_NS 40

`endif

// File: design/srs_pkg.sv
// Purpose: Types shared by the serial memory read sequencer
// Assumes: Nothing beyond the constants header
// Notes: States, bus events and the slave address byte layout
package srs_pkg;

  typedef enum logic [2:0] {
    SRS_IDLE,
    SRS_DEV,
    SRS_DEV_ACK,
    SRS_WADDR,
    SRS_RX_ACK,
    SRS_WDATA,
    SRS_RDATA,
    SRS_RACK
  } srs_state_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
  } srs_evt_t;

  typedef struct packed {
    logic [3:0] dev_type;
    logic [1:0] dont_care;
    logic bank_select_bit;
    logic rd;
  } srs_slave_addr_t;

endpackage : srs_pkg

// File: tb/srs_chk.sv
// Purpose: Port checker of srs_seq
// Assumes: Pins seen on ref_clk
// Notes: Raw start and stop sampling
`timescale 1ns/100ps
module srs_chk #(
  parameter int TWR_CYCLES = 250000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_clk,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic sda_val,
  input wire logic sda_oe,
  input wire logic standby,
  input wire logic write_busy
);
  int cnt_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge ref_clk) cnt_q <= write_busy ? cnt_q + 1 : 0;
  sequence s_start; scl_pin && $fell(sda_pin); endsequence
  sequence s_stop; scl_pin && $rose(sda_pin); endsequence
  property p_od; !sda_val && (!sda_oe || !sda_pin); endproperty
  a_od: assert property (p_od) else $error("drive does not pull data low");
  property p_launch; $rose(sda_oe) |-> !scl_pin; endproperty
  a_launch: assert property (p_launch) else $error("oe rose in scl high");
  property p_hold; scl_pin && $past(scl_pin) |-> $stable(sda_oe); endproperty
  a_hold: assert property (p_hold) else $error("oe moved in scl high");
  property p_busy; write_busy |-> !standby && !sda_oe; endproperty
  a_busy: assert property (p_busy) else $error("busy but active");
  // Window allows one cycle of synchroniser slip
  property p_twr; $fell(write_busy) |-> cnt_q inside {[TWR_CYCLES-1:TWR_CYCLES+1]}; endproperty
  a_twr: assert property (p_twr) else $error("write cycle length");
  property p_quiet; standby |-> !sda_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("standby but driving");
  property p_stop; s_stop |-> ##[1:8] (standby || write_busy); endproperty
  a_stop: assert property (p_stop) else $error("no standby after stop");
  property p_wake; s_start ##0 !write_busy |-> ##[1:8] !standby; endproperty
  a_wake: assert property (p_wake) else $error("start not taken");
endmodule : srs_chk

// File: tb/srs_master.sv
// Purpose: Two-wire bus master model
// Assumes: SDA pulled up in tb
// Notes: SCL stands high between frames
`timescale 1ns/100ps
module srs_master #(
  parameter int HP = 300
) (
  output logic scl = 1'b1,
  output logic pull = 1'b0,
  input wire logic sda
);
  // Data moves only in SCL low
  task automatic bit9(input logic b, output logic s);
    pull = !b;
    #HP scl = 1'b1;
    #(HP / 2) s = sda;
    #(HP / 2) scl = 1'b0;
  endtask : bit9
  task automatic start;
    pull = 1'b0;
    #HP scl = 1'b1;
    #HP pull = 1'b1;
    #HP scl = 1'b0;
  endtask : start
  task automatic stop;
    pull = 1'b1;
    #HP scl = 1'b1;
    #HP pull = 1'b0;
    #HP;
  endtask : stop
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) bit9(d[i], q[i]);
  endtask : xfer
endmodule : srs_master

// File: tb/srs_tb.sv
// Purpose: Self-checking bench of srs_seq
// Assumes: SCL half period 300 ns, above the oversampling floor
// Notes: Short write cycle keeps the run brief
`timescale 1ns/100ps
module tb;
  import srs_pkg::*;
  localparam int TWR = 1000;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, pull, sda_val, sda_oe, standby, write_busy;
  logic [8:0] q;
  wire logic sda = pull ? 1'b0 : (sda_oe ? sda_val : 1'b1);
  int n_mismatch = 0;
  int check_count = 0;
  srs_seq #(.TWR_CYCLES(TWR)) dut (.ref_clk(ref_clk), .rst(rst), .scl_clk(scl),
    .scl_pin(scl), .sda_pin(sda), .sda_val(sda_val), .sda_oe(sda_oe), .standby(standby),
    .write_busy(write_busy));
  srs_master m (.scl(scl), .pull(pull), .sda(sda));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic addr(input logic [8:0] a, input logic rd, input logic ack);
    m.start();
    m.xfer({4'h5, 2'b00, a[8], rd, 1'b1}, q);
    chk({7'h00, q[0]}, {7'h00, !ack});
  endtask : addr
  task automatic point(input logic [8:0] a);
    addr(a, 1'b0, 1'b1);
    m.xfer({a[7:0], 1'b1}, q);
    chk({7'h00, q[0]}, 8'h00);
  endtask : point
  task automatic wait_idle;
    int k;
    k = 0;
    while (standby !== 1'b1 && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k == 2000) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : wait_idle
  task automatic rd(input logic [7:0] e[$], input logic [8:0] a);
    addr(a, 1'b1, 1'b1);
    foreach (e[i]) begin
      m.xfer({8'hFF, i == e.size() - 1}, q);
      chk(q[8:1], e[i]);
    end
    m.stop();
    repeat (8) @(posedge ref_clk);
    chk({7'h00, standby}, 8'h01);
  endtask : rd
  task automatic t_fill;
    logic [8:0] at[4] = '{9'h0FF, 9'h100, 9'h1FF, 9'h000};
    logic [7:0] dv[4] = '{8'h11, 8'h22, 8'hA5, 8'h3C};
    foreach (at[i]) begin
      point(at[i]);
      m.xfer({dv[i], 1'b1}, q);
      m.stop();
      wait_idle();
    end
  endtask : t_fill
  // A start inside the write cycle must go unanswered
  task automatic t_busy;
    point(9'h001);
    m.xfer({8'h5A, 1'b1}, q);
    m.stop();
    addr(9'h001, 1'b0, 1'b0);
    m.stop();
    chk({7'h00, write_busy}, 8'h01);
    wait_idle();
  endtask : t_busy
  task automatic t_dummy;
    point(9'h0FF);
    m.stop();
    repeat (8) @(posedge ref_clk);
    chk({7'h00, write_busy}, 8'h00);
    rd('{8'h11, 8'h22}, 9'h000);
  endtask : t_dummy
  task automatic t_refuse;
    m.start();
    m.xfer(9'h063, q);
    chk({7'h00, q[0]}, 8'h01);
    m.stop();
  endtask : t_refuse
  // Random sequential read across the top of the array
  task automatic t_wrap;
    point(9'h1FF);
    rd('{8'hA5, 8'h3C}, 9'h1FF);
  endtask : t_wrap
  task automatic t_current;
    rd('{8'h5A}, 9'h000);
  endtask : t_current
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    forever #20 ref_clk = !ref_clk;
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #7;
    t_fill();
    t_busy();
    t_dummy();
    t_wrap();
    t_current();
    t_refuse();
    print_verdict();
  end
endmodule : tb
bind srs_seq srs_chk #(.TWR_CYCLES(TWR_CYCLES)) u_chk (.ref_clk(ref_clk), .rst(rst),
  .scl_clk(scl_clk), .scl_pin(scl_pin), .sda_pin(sda_pin), .sda_val(sda_val), .sda_oe(sda_oe),
  .standby(standby), .write_busy(write_busy));
